/* verilog/wrwc_consts.svh */
`ifndef WRWC_CONSTS_SVH
`define WRWC_CONSTS_SVH
// Clock and time bases
`define WRWC_CLK_MHZ 20
`define WRWC_CYC_PER_MS (`WRWC_CLK_MHZ * 1000)
// Watchdog periods and other timings in ms
`define WRWC_WD_P0_MS 10
`define WRWC_WD_P1_MS 45
`define WRWC_WD_P2_MS 100
`define WRWC_WD_P3_MS 350
`define WRWC_NREQ_MS 350
`define WRWC_RST_DUR_MS 15
`define WRWC_CYC_SENSE_MS 20
`define WRWC_FWU_MS 100
// Interrupt pulse in ns and its cycle count
`define WRWC_INT_PULSE_NS 10000
`define WRWC_INT_PULSE_CYC ((`WRWC_INT_PULSE_NS * `WRWC_CLK_MHZ) / 1000)
// High-side on time per cyclic sense period, cycles
`define WRWC_HS_ON_CYC 32'h0000_0040
// Serial frame: addr[7:5], write bit 4, data [3:0]
`define WRWC_SPI_BITS 4'h8
`define WRWC_ADDR_MCR 3'h0
`define WRWC_ADDR_WUR 3'h4
`define WRWC_ADDR_TIM 3'h5
`define WRWC_ADDR_LPC 3'h6
// Mode control data codes
`define WRWC_MCR_NORMAL 4'h1
`define WRWC_MCR_STANDBY 4'h2
`define WRWC_MCR_STOP 4'h3
`define WRWC_MCR_SLEEP 4'h4
// Timing subregister fields
`define WRWC_TIM_WIN_BIT 2
`define WRWC_TIM_WIN_RST 1'b0
// Low power control fields
`define WRWC_LPC_BIAS_BIT 3
`define WRWC_LPC_FWU_BIT 1
`define WRWC_LPC_AUTO_BIT 0
// Level sense codes per pair
`define WRWC_SENSE_HIGH 2'h1
`define WRWC_SENSE_LOW 2'h2
`define WRWC_SENSE_ANY 2'h3
// AXI4-Lite byte addresses and response codes
`define WRWC_REG_STATUS 4'h0
`define WRWC_REG_WAKE 4'h4
`define WRWC_REG_CONFIG 4'h8
`define WRWC_RESP_OKAY 2'h0
`define WRWC_RESP_SLVERR 2'h2
`endif

/* verilog/wrwc_pkg.sv */
package wrwc_pkg;
  // Device operating modes, one-hot
  typedef enum logic [5:0] {
    WRWC_RESET   = 6'h01,
    WRWC_NREQ    = 6'h02,
    WRWC_NORMAL  = 6'h04,
    WRWC_STANDBY = 6'h08,
    WRWC_STOP    = 6'h10,
    WRWC_SLEEP   = 6'h20
  } wrwc_state_e;
endpackage : wrwc_pkg

/* verilog/wrwc_sync.sv */
`timescale 1ns/1ps
module wrwc_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Raw input and filtered output
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // Three stages; the first is read only by the second
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // Shift chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Accept a bit once stages two and three agree
  genvar i;
  for (i = 0; i < W; i++) begin : g_agree
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        dout[i] <= RST_VAL[i];
      end else if (s2_q[i] == s3_q[i]) begin
        dout[i] <= s2_q[i];
      end
    end
  end
endmodule : wrwc_sync

/* verilog/wrwc_top.sv */
`timescale 1ns/1ps
`include "wrwc_consts.svh"
module wrwc_top import wrwc_pkg::*; #(
  parameter int unsigned WD_P0_CYC = `WRWC_WD_P0_MS * `WRWC_CYC_PER_MS,
  parameter int unsigned WD_P1_CYC = `WRWC_WD_P1_MS * `WRWC_CYC_PER_MS,
  parameter int unsigned WD_P2_CYC = `WRWC_WD_P2_MS * `WRWC_CYC_PER_MS,
  parameter int unsigned WD_P3_CYC = `WRWC_WD_P3_MS * `WRWC_CYC_PER_MS,
  parameter int unsigned NREQ_CYC = `WRWC_NREQ_MS * `WRWC_CYC_PER_MS,
  parameter int unsigned RST_DUR_CYC = `WRWC_RST_DUR_MS * `WRWC_CYC_PER_MS,
  parameter int unsigned CYC_SENSE_CYC = `WRWC_CYC_SENSE_MS * `WRWC_CYC_PER_MS,
  parameter int unsigned FWU_CYC = `WRWC_FWU_MS * `WRWC_CYC_PER_MS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial link from host
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  // Supply and wake pins
  input wire logic vdd_ok,
  input wire logic [3:0] wake_inputs,
  input wire logic can_wake_event,
  // Host outputs
  output logic host_reset_n,
  output logic watchdog_fail_output_n,
  output logic int_n,
  output logic vreg_enable,
  output logic high_side_switch,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edges
  logic [7:0] sy; // Filtered pins
  logic sclk_p_q; // Previous filtered clock
  logic cs_p_q; // Previous filtered select
  logic can_p_q; // Previous CAN wake line
  wrwc_sync #(.W(8), .RST_VAL(8'h06)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({can_wake_event, wake_inputs, vdd_ok, spi_cs_n, spi_sclk}),
    .dout(sy)
  );
  // Edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_p_q <= 1'b0;
      cs_p_q <= 1'b1;
      can_p_q <= 1'b0;
    end else begin
      sclk_p_q <= sy[0];
      cs_p_q <= sy[1];
      can_p_q <= sy[7];
    end
  end
  wire sclk_rise = sy[0] & ~sclk_p_q;
  wire sclk_fall = ~sy[0] & sclk_p_q;
  wire cs_rise = sy[1] & ~cs_p_q;
  wire cs_fall = ~sy[1] & cs_p_q;
  wire vdd_good = sy[2];
  wire [3:0] lin = sy[6:3];
  wire can_rise = sy[7] & ~can_p_q;

  ////////////////////////////////////////////////////////////////////////
  // Serial receiver
  wrwc_state_e state_q, state_d;
  logic [7:0] rx_q; // Incoming frame
  logic [3:0] bits_q; // Bits received
  logic [7:0] tx_q; // Outgoing wake-up register image
  logic [3:0] flags_q; // Wake sources: inputs, CAN, select, forced
  logic spi_mosi_s; // Filtered serial data, aligned with the filtered clock
  // Shift on sclk edges while selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_q <= 8'h00;
      bits_q <= 4'h0;
    end else if (cs_fall) begin
      bits_q <= 4'h0;
    end else if (!sy[1] && sclk_rise && bits_q != `WRWC_SPI_BITS) begin
      rx_q <= {rx_q[6:0], spi_mosi_s};
      bits_q <= bits_q + 4'h1;
    end
  end
  // Mosi is sampled from the filtered stage via a second instance
  wrwc_sync #(.W(1), .RST_VAL(1'b0)) u_mosi (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(spi_mosi),
    .dout(spi_mosi_s)
  );
  // Miso shifts the wake-up register out, MSB first
  // input port readback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_q <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= ~sy[1];
      if (cs_fall) begin
        tx_q <= {lin, flags_q};
        spi_miso <= lin[3];
      end else if (!sy[1] && sclk_fall) begin
        tx_q <= {tx_q[6:0], 1'b0};
        spi_miso <= tx_q[6];
      end
    end
  end
  // Frame complete; commands are ignored in low power
  wire lowpower = (state_q == WRWC_STOP) || (state_q == WRWC_SLEEP);
  wire frame = cs_rise && bits_q == `WRWC_SPI_BITS && !lowpower;
  wire [2:0] f_addr = rx_q[7:5];
  wire f_wr = rx_q[4];
  wire [3:0] f_dat = rx_q[3:0];
  // timing subregister write is the trigger
  wire tim_wr = frame && f_wr && f_addr == `WRWC_ADDR_TIM;
  wire mcr_wr = frame && f_wr && f_addr == `WRWC_ADDR_MCR;
  wire lpc_wr = frame && f_wr && f_addr == `WRWC_ADDR_LPC;
  wire wur_wr = frame && f_wr && f_addr == `WRWC_ADDR_WUR;
  wire wur_rd = frame && !f_wr && f_addr == `WRWC_ADDR_WUR;

  ////////////////////////////////////////////////////////////////////////
  // Serial configuration registers
  logic win_timeout_q; // 0 window, 1 time-out
  logic [1:0] per_sel_q; // Period select
  logic bias_q, auto_q, fwu_q; // Low-power options
  logic [3:0] sense_q; // Pair sensitivities
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_timeout_q <= `WRWC_TIM_WIN_RST;
      per_sel_q <= 2'h0;
    end else if (tim_wr) begin
      win_timeout_q <= f_dat[`WRWC_TIM_WIN_BIT];
      per_sel_q <= f_dat[1:0];
    end
  end
  // Options are only writable outside low power
  // configured before low power
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bias_q <= 1'b0;
      auto_q <= 1'b0;
      fwu_q <= 1'b0;
      sense_q <= 4'h0;
    end else begin
      if (lpc_wr) begin
        bias_q <= f_dat[`WRWC_LPC_BIAS_BIT];
        auto_q <= f_dat[`WRWC_LPC_AUTO_BIT];
        fwu_q <= f_dat[`WRWC_LPC_FWU_BIT];
      end
      if (wur_wr) begin
        sense_q <= f_dat;
      end
    end
  end
  // forced wake locks out cyclic sense
  wire cyclic = bias_q & auto_q & ~fwu_q;
  // direct wake when bias and auto cleared
  wire direct = ~bias_q & ~auto_q;

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  logic [31:0] wd_q; // Elapsed cycles in the period
  logic [31:0] per_cyc; // Selected period
  always_comb begin
    case (per_sel_q)
      2'h0: per_cyc = 32'(WD_P0_CYC);
      2'h1: per_cyc = 32'(WD_P1_CYC);
      2'h2: per_cyc = 32'(WD_P2_CYC);
      default: per_cyc = 32'(WD_P3_CYC);
    endcase
  end
  wire wd_active = state_q inside {WRWC_NORMAL, WRWC_STANDBY, WRWC_STOP};
  // closed window is the first half
  wire closed = !win_timeout_q && wd_q < {1'b0, per_cyc[31:1]};
  // closed-window service faults only in Normal and Standby, not in Stop
  wire early = wd_active && tim_wr && closed && state_q != WRWC_STOP;
  wire late = wd_active && wd_q >= per_cyc - 32'h1;
  wire wd_fault = early | late;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_q <= 32'h0;
    end else if (!wd_active || tim_wr) begin
      wd_q <= 32'h0;
    end else begin
      wd_q <= wd_q + 32'h1;
    end
  end
  // fail flag: set by a fault, cleared by a later service
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_fail_output_n <= 1'b1;
    end else if (wd_fault) begin
      watchdog_fail_output_n <= 1'b0;
    end else if (tim_wr) begin
      watchdog_fail_output_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake detection
  logic [3:0] ref_q; // Input levels at low-power entry
  logic [31:0] lp_q; // Time spent in low power
  logic [3:0] hit; // Per-input wake condition
  logic can_wake_en_q; // Software CAN wake enable
  // one method for all, sense per pair
  genvar g;
  for (g = 0; g < 4; g++) begin : g_wake
    wire [1:0] s = sense_q[2*(g/2)+:2];
    assign hit[g] = (s == `WRWC_SENSE_HIGH && lin[g]) ||
                    (s == `WRWC_SENSE_LOW && !lin[g]) ||
                    (s == `WRWC_SENSE_ANY && lin[g] != ref_q[g]);
  end
  wire [31:0] cyc_ph = lp_q % 32'(CYC_SENSE_CYC);
  // high side on at the end of each sense period
  wire hs_on = cyclic && lowpower &&
               cyc_ph >= 32'(CYC_SENSE_CYC) - `WRWC_HS_ON_CYC;
  wire hs_sample = hs_on && cyc_ph == 32'(CYC_SENSE_CYC) - 32'h1;
  wire in_wake = lowpower && (|hit) && (direct || hs_sample);
  // CAN wake gated by its own enable
  wire can_wake = lowpower && can_wake_en_q && can_rise;
  wire cs_wake = lowpower && cs_rise;
  wire fwu_wake = lowpower && fwu_q && lp_q >= 32'(FWU_CYC) - 32'h1;
  wire wake = in_wake | can_wake | cs_wake | fwu_wake;
  // Low-power timer and reference capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_q <= 32'h0;
      ref_q <= 4'h0;
    end else if (!lowpower) begin
      lp_q <= 32'h0;
      ref_q <= lin;
    end else begin
      lp_q <= lp_q + 32'h1;
    end
  end
  // sticky sources, set wins over the read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= (wur_rd ? 4'h0 : flags_q) |
                 {fwu_wake, cs_wake, can_wake, in_wake};
    end
  end
  // Cyclic pulse to the high-side switch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_side_switch <= 1'b0;
    end else begin
      high_side_switch <= hs_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode state machine
  logic [31:0] mt_q; // Time in Reset or Normal Request
  always_comb begin
    state_d = state_q;
    case (state_q)
      // hold reset until supply good and duration spent
      WRWC_RESET: begin
        if (vdd_good && mt_q >= 32'(RST_DUR_CYC) - 32'h1) begin
          state_d = WRWC_NREQ;
        end
      end
      // unserviced Normal Request falls back to Reset
      WRWC_NREQ: begin
        if (tim_wr) begin
          state_d = WRWC_NORMAL;
        end else if (mt_q >= 32'(NREQ_CYC) - 32'h1) begin
          state_d = WRWC_RESET;
        end
      end
      WRWC_NORMAL, WRWC_STANDBY: begin
        if (mcr_wr && f_dat == `WRWC_MCR_NORMAL) begin
          state_d = WRWC_NORMAL;
        end else if (mcr_wr && f_dat == `WRWC_MCR_STANDBY) begin
          state_d = WRWC_STANDBY;
        end else if (mcr_wr && f_dat == `WRWC_MCR_STOP) begin
          state_d = WRWC_STOP;
        end else if (mcr_wr && f_dat == `WRWC_MCR_SLEEP) begin
          state_d = WRWC_SLEEP;
        end
      end
      // Stop wake goes to Normal Request
      WRWC_STOP: begin
        if (wake) begin
          state_d = WRWC_NREQ;
        end
      end
      WRWC_SLEEP: begin
        if (wake) begin
          state_d = WRWC_RESET;
        end
      end
      default: state_d = WRWC_RESET;
    endcase
    // undervoltage outside Sleep or watchdog fault forces Reset
    if ((!vdd_good && state_q != WRWC_SLEEP) || wd_fault) begin
      state_d = WRWC_RESET;
    end
  end
  // State and mode timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= WRWC_RESET;
      mt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q || (state_q == WRWC_RESET && !vdd_good)) begin
        mt_q <= 32'h0;
      end else begin
        mt_q <= mt_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host outputs
  logic [7:0] int_cnt_q; // Remaining interrupt pulse cycles
  // reset low in Reset and Sleep
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_reset_n <= 1'b0;
      vreg_enable <= 1'b1;
    end else begin
      host_reset_n <= !(state_d inside {WRWC_RESET, WRWC_SLEEP});
      vreg_enable <= state_d != WRWC_SLEEP;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_cnt_q <= 8'h00;
      int_n <= 1'b1;
    end else begin
      if (state_q == WRWC_STOP && state_d == WRWC_NREQ) begin
        int_cnt_q <= 8'(`WRWC_INT_PULSE_CYC);
      end else if (int_cnt_q != 8'h00) begin
        int_cnt_q <= int_cnt_q - 8'h01;
      end
      int_n <= !(int_cnt_q != 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic aw_h_q, w_h_q; // Address and data taken
  logic [3:0] aw_a_q; // Held write address
  logic [31:0] w_d_q; // Held write data
  logic w_s_q; // Held lane 0 strobe
  // Capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h_q <= 1'b0;
      w_h_q <= 1'b0;
      aw_a_q <= 4'h0;
      w_d_q <= 32'h0;
      w_s_q <= 1'b0;
    end else if (aw_h_q && w_h_q) begin
      aw_h_q <= 1'b0;
      w_h_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h_q <= 1'b1;
        aw_a_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h_q <= 1'b1;
        w_d_q <= s_axi_wdata;
        w_s_q <= s_axi_wstrb[0];
      end
    end
  end
  assign s_axi_awready = !aw_h_q && !s_axi_bvalid;
  assign s_axi_wready = !w_h_q && !s_axi_bvalid;
  // Write execute and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      can_wake_en_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WRWC_RESP_OKAY;
    end else if (aw_h_q && w_h_q) begin
      s_axi_bvalid <= 1'b1;
      if (aw_a_q == `WRWC_REG_CONFIG) begin
        s_axi_bresp <= `WRWC_RESP_OKAY;
        if (w_s_q) begin
          can_wake_en_q <= w_d_q[0];
        end
      end else if (aw_a_q == `WRWC_REG_STATUS || aw_a_q == `WRWC_REG_WAKE) begin
        s_axi_bresp <= `WRWC_RESP_OKAY;
      end else begin
        s_axi_bresp <= `WRWC_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  // Read path, one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `WRWC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `WRWC_RESP_OKAY;
      if (s_axi_araddr == `WRWC_REG_STATUS) begin
        s_axi_rdata <= {20'h0, watchdog_fail_output_n, host_reset_n,
                        win_timeout_q, per_sel_q[0], state_q, 2'b0} >> 2;
      end else if (s_axi_araddr == `WRWC_REG_WAKE) begin
        s_axi_rdata <= {24'h0, lin, flags_q};
      end else if (s_axi_araddr == `WRWC_REG_CONFIG) begin
        s_axi_rdata <= {31'h0, can_wake_en_q};
      end else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `WRWC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_stop_wake; state_q == WRWC_STOP && wake && vdd_good && !late; endsequence
  sequence s_int_low; !int_n [*8]; endsequence
  property p_closed_fault;
    early |=> state_q == WRWC_RESET ##1 !host_reset_n;
  endproperty
  a_closed_fault: assert property (p_closed_fault) else $error("closed write no reset");
  property p_stop_closed;
    state_q == WRWC_STOP && tim_wr && closed && !late && vdd_good |=> state_q != WRWC_RESET;
  endproperty
  a_stop_closed: assert property (p_stop_closed) else $error("stop closed write reset");
  property p_uv;
    !vdd_good && state_q != WRWC_SLEEP |=> state_q == WRWC_RESET && !host_reset_n;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage no reset");
  property p_fail_set;
    wd_fault |=> !watchdog_fail_output_n && state_q == WRWC_RESET;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail not set");
  property p_fail_hold;
    !watchdog_fail_output_n && !tim_wr |=> !watchdog_fail_output_n;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail released early");
  property p_sleep_wake;
    state_q == WRWC_SLEEP && wake |=> state_q == WRWC_RESET && vreg_enable;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake path");
  property p_stop_int;
    s_stop_wake |=> state_q == WRWC_NREQ ##2 s_int_low;
  endproperty
  a_stop_int: assert property (p_stop_int) else $error("stop wake interrupt");
  property p_excl;
    fwu_q |=> !high_side_switch;
  endproperty
  a_excl: assert property (p_excl) else $error("cyclic with forced wake");
  property p_nreq_to;
    state_q == WRWC_NREQ && !tim_wr && !$past(tim_wr) |-> mt_q < 32'(NREQ_CYC);
  endproperty
  a_nreq_to: assert property (p_nreq_to) else $error("request timer overrun");
endmodule : wrwc_top

/* testbench/wrwc_host.sv */
`timescale 1ns/1ps
// Host end of the serial link; select idles high, clock idles low
module wrwc_host (
  // Serial pins
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  task automatic send(input logic [7:0] b);
    spi_cs_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = b[i];
      #200 spi_sclk = 1'b1;
      #200 spi_sclk = 1'b0;
    end
    #200 spi_cs_n = 1'b1;
    // Released data line shows the inverse, not a stale bit
    spi_mosi = ~b[0];
    #400;
  endtask : send
endmodule : wrwc_host

/* testbench/watchdog_reset_wakeup_control_tb.sv */
`timescale 1ns/1ps
module watchdog_reset_wakeup_control_tb;
  import wrwc_pkg::*;
  localparam int RST = 100;
  logic aclk, aresetn, vdd_ok, can_wake_event, spi_sclk, spi_cs_n, spi_mosi;
  logic spi_miso, spi_miso_oe, host_reset_n, watchdog_fail_output_n, int_n;
  logic vreg_enable, high_side_switch, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0] wake_inputs, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int bad_count, checks_done, n;
  // Short counts keep the run brief
  wrwc_top #(.WD_P0_CYC(200), .WD_P1_CYC(400), .WD_P2_CYC(600), .WD_P3_CYC(800),
    .NREQ_CYC(2000), .RST_DUR_CYC(RST), .CYC_SENSE_CYC(200), .FWU_CYC(300)) dut (
    .aclk, .aresetn, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .vdd_ok,
    .wake_inputs, .can_wake_event, .host_reset_n, .watchdog_fail_output_n, .int_n,
    .vreg_enable, .high_side_switch, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  wrwc_host host (.spi_sclk, .spi_cs_n, .spi_mosi);
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  // Bounded wait for the host reset pin; n holds the cycles spent
  task automatic rst_wait(input logic v, input int lim);
    n = 0;
    while (host_reset_n !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
  endtask : rst_wait
  // Handshakes are judged at the falling edge, i.e. as the next rising edge sees them
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw_t, w_t, b_t;
    logic [1:0] br;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready === 1'b1;
      w_t = s_axi_wvalid && s_axi_wready === 1'b1;
      b_t = s_axi_bvalid === 1'b1;
      br = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      n++;
    end while (!b_t && n < 50);
    s_axi_bready <= 1'b0;
    if (!b_t) bad_count++;
    cmp(br, e);
  endtask : axw
  task automatic axr(input logic [3:0] a);
    logic ar_t, r_t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready === 1'b1;
      r_t = s_axi_rvalid === 1'b1;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
      n++;
    end while (!r_t && n < 50);
    s_axi_rready <= 1'b0;
    if (!r_t) bad_count++;
  endtask : axr
  task automatic st(input logic [5:0] e);
    axr(4'h0);
    cmp(rd[5:0], e);
  endtask : st
  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Hang guard, well beyond the sequence length
  initial begin
    #2000000;
    bad_count++;
    conclude();
  end
  initial begin
    bad_count = 0;
    checks_done = 0;
    aresetn = 1'b0;
    vdd_ok = 1'b1;
    wake_inputs = 4'ha;
    can_wake_event = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    cyc(16);
    aresetn <= 1'b1;
    cyc(50);
    cmp(host_reset_n, 1'b0);
    st(WRWC_RESET);
    rst_wait(1'b1, RST);
    st(WRWC_NREQ);
    axr(4'h4);
    cmp(rd[7:4], 4'ha);
    cyc(1700);
    cmp(host_reset_n, 1'b1);
    rst_wait(1'b0, 600);
    cmp(host_reset_n, 1'b0);
    rst_wait(1'b1, RST + 20);
    host.send(8'hb3);
    st(WRWC_NORMAL);
    cmp(rd[7], 1'b0);
    // Second service lands in the closed window
    host.send(8'hb3);
    cmp(host_reset_n, 1'b0);
    cmp(watchdog_fail_output_n, 1'b0);
    rst_wait(1'b1, RST + 20);
    cmp(watchdog_fail_output_n, 1'b0);
    host.send(8'hb3);
    cmp(watchdog_fail_output_n, 1'b1);
    cyc(500);
    host.send(8'hb3);
    cyc(600);
    cmp(host_reset_n, 1'b1);
    rst_wait(1'b0, 800);
    cmp(watchdog_fail_output_n, 1'b0);
    rst_wait(1'b1, RST + 20);
    cmp(n >= RST - 2 && n <= RST + 10, 1'b1);
    host.send(8'hb3);
    host.send(8'h13);
    st(WRWC_STOP);
    host.send(8'h00);
    cyc(4);
    cmp(int_n, 1'b0);
    st(WRWC_NREQ);
    axr(4'h4);
    cmp(rd[2], 1'b1);
    host.send(8'hb3);
    vdd_ok <= 1'b0;
    cyc(10);
    cmp({host_reset_n, watchdog_fail_output_n}, 2'b01);
    vdd_ok <= 1'b1;
    rst_wait(1'b1, RST + 20);
    host.send(8'hb3);
    host.send(8'h14);
    cmp(vreg_enable, 1'b0);
    host.send(8'h00);
    cmp({vreg_enable, host_reset_n}, 2'b10);
    axw(4'h8, 32'h1, 2'h0);
    axr(4'h8);
    cmp(rd, 32'h1);
    s_axi_wstrb <= 4'he;
    axw(4'h8, 32'h0, 2'h0);
    axr(4'h8);
    cmp(rd, 32'h1);
    s_axi_wstrb <= 4'hf;
    axw(4'hc, 32'h1, 2'h2);
    axr(4'hc);
    cmp(rr, 2'h2);
    // CAN edge wakes Stop once enabled; inputs read back as a port
    rst_wait(1'b1, RST + 20);
    host.send(8'hb3);
    host.send(8'hd0);
    host.send(8'h13);
    st(WRWC_STOP);
    can_wake_event <= 1'b1;
    wake_inputs <= 4'h5;
    cyc(10);
    can_wake_event <= 1'b0;
    st(WRWC_NREQ);
    axr(4'h4);
    cmp(rd[1], 1'b1);
    cmp(rd[7:4], 4'h5);
    conclude();
  end
endmodule : watchdog_reset_wakeup_control_tb
